// *** rtl/ctbt_core.sv ***
/*
  ctbt_core: touch burst timing sequencer, prescalers, burst lengths,
  sense clamping, count buffer, register port and interrupt.
  assumes: register master per the plain strobe port; sense_cmp is
  synchronous to core_clk; DMA watches the two request outputs.
*/
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module ctbt_core (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic [7:0] sense_cmp,
  output logic [7:0] drive_out,
  output logic [7:0] sense_ground,
  output logic [7:0] clamp_ground,
  output logic self_charge,
  output logic cx_discharge,
  output logic burst_length_request,
  output logic dma_count_req,
  output logic irq
);
  // ==========================================================
  // functions
  function automatic logic [7:0] cfg0_addr(input int unsigned t);
    cfg0_addr = ctbt_pkg::OFF_CFG_BASE + 8'(t) * ctbt_pkg::OFF_CFG_STEP;
  endfunction

  function automatic logic [7:0] max_burst(input logic [63:0] b, input logic [2:0] last);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (3'(i) <= last && b[8*i +: 8] > m) m = b[8*i +: 8];
    end
    max_burst = m;
  endfunction

  // ==========================================================
  // registers
  ctbt_pkg::ctbt_state_e state, next_state;
  logic [9:0] ctrl;
  logic [23:0] cfg0 [ctbt_pkg::NTYPES];
  logic [7:0] cfg1 [ctbt_pkg::NTYPES];
  logic [7:0] cx_len;
  logic [63:0] burst;
  logic grp;
  logic [2:0] status, mask;
  logic [7:0] phase_cnt, pulse_left;
  logic [2:0] drive_idx, store_idx;
  logic [7:0] cnt [ctbt_pkg::NLINES];
  logic [4:0] wptr, wptr_d, rptr, next_rptr;
  logic [15:0] mem_q;
  logic [3:0] ticks;

  logic [1:0] typ;
  logic matrix, enabled, start, tick, phase_zero, pulse_end;
  logic wr_burst, last_grp, fifo_full, fifo_empty, fifo_wr, pop, store_last;
  logic [2:0] nsense_m1, ndrive_m1, status_set;
  logic [7:0] capture;
  logic [31:0] next_rd;

  assign typ = ctrl[ctbt_pkg::CTRL_TYPE_LSB +: 2];
  assign matrix = (typ == ctbt_pkg::TYPE_MATRIX);
  assign enabled = ctrl[ctbt_pkg::CTRL_EN_BIT];
  assign nsense_m1 = ctrl[ctbt_pkg::CTRL_NSENSE_LSB +: 3];
  assign ndrive_m1 = ctrl[ctbt_pkg::CTRL_NDRIVE_LSB +: 3];
  assign start = wr_en && addr == ctbt_pkg::OFF_CTRL && wr_data[ctbt_pkg::CTRL_START_BIT];
  assign tick = ticks[typ];
  assign phase_zero = (phase_cnt == 8'h00);
  assign wr_burst = wr_en && addr == ctbt_pkg::OFF_BURST && state == ctbt_pkg::ST_REQ;
  assign last_grp = ({grp, 2'b11} >= nsense_m1);
  assign fifo_full = (wptr[3:0] == rptr[3:0]) && (wptr[4] != rptr[4]);
  assign fifo_empty = (wptr_d == rptr);
  assign store_last = matrix ? (store_idx == nsense_m1) : 1'b1;
  assign fifo_wr = (state == ctbt_pkg::ST_STORE) && !fifo_full;
  assign pop = rd_en && addr == ctbt_pkg::OFF_COUNT && !fifo_empty;
  assign next_rptr = pop ? rptr + 5'h01 : rptr;
  assign pulse_end = matrix ? (pulse_left <= 8'h01) : (sense_cmp[0] || cnt[0] == 8'hFF);

  // ==========================================================
  // prescalers, one per type, matrix last
  for (genvar t = 0; t < ctbt_pkg::NTYPES; t++) begin : g_presc
    ctbt_prescaler u_presc (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .div(cfg0[t][ctbt_pkg::DIV_LSB +: 8]),
      .tick(ticks[t])
    );
  end

  // ==========================================================
  // capture selection, matrix lines staggered so all end together; self types capture line zero only
  always_comb begin
    for (int i = 0; i < ctbt_pkg::NLINES; i++) begin
      if (matrix) begin
        capture[i] = 3'(i) <= nsense_m1 && burst[8*i +: 8] != 8'h00 &&
                     burst[8*i +: 8] >= pulse_left;
      end else begin
        capture[i] = (i == 0);
      end
    end
  end

  // ==========================================================
  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      ctbt_pkg::ST_IDLE: begin
        if (start) next_state = matrix ? ctbt_pkg::ST_REQ : ctbt_pkg::ST_CHARGE;
      end
      ctbt_pkg::ST_REQ: begin
        if (wr_burst && last_grp) next_state = ctbt_pkg::ST_CXDIS;
      end
      ctbt_pkg::ST_CXDIS: begin
        if (tick && phase_zero) next_state = ctbt_pkg::ST_CHARGE;
      end
      ctbt_pkg::ST_CHARGE: begin
        if (tick && phase_zero) next_state = ctbt_pkg::ST_SETTLE;
      end
      ctbt_pkg::ST_SETTLE: begin
        if (tick && phase_zero) next_state = ctbt_pkg::ST_DISCH;
      end
      ctbt_pkg::ST_DISCH: begin
        if (tick && phase_zero) begin
          next_state = pulse_end ? ctbt_pkg::ST_STORE : ctbt_pkg::ST_CHARGE;
        end
      end
      ctbt_pkg::ST_STORE: begin
        if (fifo_wr && store_last) begin
          next_state = (matrix && drive_idx != ndrive_m1) ? ctbt_pkg::ST_REQ : ctbt_pkg::ST_DONE;
        end
      end
      ctbt_pkg::ST_DONE: begin
        next_state = ctbt_pkg::ST_IDLE;
      end
      default: begin
        next_state = ctbt_pkg::ST_IDLE;
      end
    endcase
    if (!enabled) next_state = ctbt_pkg::ST_IDLE;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ctbt_pkg::ST_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // phase timing in prescaler ticks
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      phase_cnt <= 8'h00;
    end else if (ce) begin
      if (state != next_state) begin
        case (next_state)
          ctbt_pkg::ST_CXDIS: phase_cnt <= cx_len;
          ctbt_pkg::ST_CHARGE: phase_cnt <= cfg0[typ][ctbt_pkg::CHARGE_LSB +: 8];
          ctbt_pkg::ST_SETTLE: phase_cnt <= cfg0[typ][ctbt_pkg::SETTLE_LSB +: 8];
          ctbt_pkg::ST_DISCH: phase_cnt <= cfg1[typ];
          default: phase_cnt <= 8'h00;
        endcase
      end else if (tick && !phase_zero) begin
        phase_cnt <= phase_cnt - 8'h01;
      end
    end
  end

  // pulses left in the burst, drive line and store index
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pulse_left <= 8'h00;
      drive_idx <= 3'h0;
      store_idx <= 3'h0;
    end else if (ce) begin
      if (state == ctbt_pkg::ST_CXDIS && next_state == ctbt_pkg::ST_CHARGE) begin
        pulse_left <= max_burst(burst, nsense_m1);
      end else if (state == ctbt_pkg::ST_DISCH && tick && phase_zero && pulse_left != 8'h00) begin
        pulse_left <= pulse_left - 8'h01;
      end
      if (state == ctbt_pkg::ST_IDLE) begin
        drive_idx <= 3'h0;
      end else if (state == ctbt_pkg::ST_STORE && next_state == ctbt_pkg::ST_REQ) begin
        drive_idx <= drive_idx + 3'h1;
      end
      if (state != ctbt_pkg::ST_STORE) begin
        store_idx <= 3'h0;
      end else if (fifo_wr) begin
        store_idx <= store_idx + 3'h1;
      end
    end
  end

  // per line counts of captured pulses
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < ctbt_pkg::NLINES; i++) cnt[i] <= 8'h00;
    end else if (ce) begin
      for (int i = 0; i < ctbt_pkg::NLINES; i++) begin
        if (state == ctbt_pkg::ST_IDLE || state == ctbt_pkg::ST_REQ) begin
          cnt[i] <= 8'h00;
        end else if (state == ctbt_pkg::ST_DISCH && tick && phase_zero && capture[i] &&
                     (!matrix || !sense_cmp[i]) && cnt[i] != 8'hFF) begin
          cnt[i] <= cnt[i] + 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // burst lengths and request handshake
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      burst <= 64'h0;
      grp <= 1'b0;
      burst_length_request <= 1'b0;
    end else if (ce) begin
      if (next_state == ctbt_pkg::ST_REQ && state != ctbt_pkg::ST_REQ) begin
        burst_length_request <= 1'b1;
        grp <= 1'b0;
      end else if (wr_burst) begin
        burst[32*grp +: 32] <= wr_data;
        grp <= ~grp;
        if (last_grp) burst_length_request <= 1'b0;
      end else if (next_state != ctbt_pkg::ST_REQ) begin
        burst_length_request <= 1'b0;
      end
    end
  end

  // ==========================================================
  // pins, driven from the current phase
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      drive_out <= 8'h00;
      sense_ground <= 8'hFF;
      clamp_ground <= 8'hFF;
      self_charge <= 1'b0;
      cx_discharge <= 1'b0;
    end else if (ce) begin
      for (int i = 0; i < ctbt_pkg::NLINES; i++) begin
        drive_out[i] <= matrix && state == ctbt_pkg::ST_CHARGE && drive_idx == 3'(i);
        sense_ground[i] <= !(state == ctbt_pkg::ST_CHARGE && capture[i]);
        clamp_ground[i] <= !(state == ctbt_pkg::ST_CHARGE && capture[i]);
      end
      self_charge <= !matrix && state == ctbt_pkg::ST_CHARGE;
      cx_discharge <= state == ctbt_pkg::ST_CXDIS;
    end
  end

  // ==========================================================
  // count buffer
  ctbt_count_mem u_mem (
    .core_clk(core_clk),
    .ce(ce),
    .wr_en(fifo_wr),
    .wr_addr(wptr[3:0]),
    .wr_data({2'b00, drive_idx, store_idx, cnt[store_idx]}),
    .rd_addr(next_rptr[3:0]),
    .rd_data(mem_q)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wptr <= 5'h00;
      wptr_d <= 5'h00;
      rptr <= 5'h00;
      dma_count_req <= 1'b0;
    end else if (ce) begin
      if (fifo_wr) wptr <= wptr + 5'h01;
      wptr_d <= wptr;
      rptr <= next_rptr;
      dma_count_req <= (wptr_d != next_rptr);
    end
  end

  // ==========================================================
  // register port
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl <= ctbt_pkg::CTRL_RESET;
      cx_len <= ctbt_pkg::LEN_RESET;
      mask <= ctbt_pkg::STATUS_RESET;
      for (int t = 0; t < ctbt_pkg::NTYPES; t++) begin
        cfg0[t] <= ctbt_pkg::CFG0_RESET;
        cfg1[t] <= ctbt_pkg::LEN_RESET;
      end
    end else if (ce && wr_en) begin
      if (addr == ctbt_pkg::OFF_CTRL) ctrl <= wr_data[9:0] & 10'h3FD;
      if (addr == ctbt_pkg::OFF_MG_CFG2) cx_len <= wr_data[7:0];
      if (addr == ctbt_pkg::OFF_MASK) mask <= wr_data[2:0];
      for (int t = 0; t < ctbt_pkg::NTYPES; t++) begin
        if (addr == cfg0_addr(t)) cfg0[t] <= wr_data[23:0];
        if (addr == cfg0_addr(t) + ctbt_pkg::OFF_CFG_ONE) cfg1[t] <= wr_data[7:0];
      end
    end
  end

  always_comb begin
    next_rd = 32'h0;
    case (addr)
      ctbt_pkg::OFF_CTRL: next_rd = {22'h0, ctrl};
      ctbt_pkg::OFF_MG_CFG2: next_rd = {24'h0, cx_len};
      ctbt_pkg::OFF_COUNT: next_rd = fifo_empty ? 32'h0 : {16'h0, mem_q};
      ctbt_pkg::OFF_STATUS: next_rd = {29'h0, status};
      ctbt_pkg::OFF_MASK: next_rd = {29'h0, mask};
      ctbt_pkg::OFF_STATE: next_rd = {16'h0, state, 1'b0, drive_idx, grp, fifo_empty,
                                      fifo_full, burst_length_request};
      default: next_rd = 32'h0;
    endcase
    for (int t = 0; t < ctbt_pkg::NTYPES; t++) begin
      if (addr == cfg0_addr(t)) next_rd = {8'h0, cfg0[t]};
      if (addr == cfg0_addr(t) + ctbt_pkg::OFF_CFG_ONE) next_rd = {24'h0, cfg1[t]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_data <= 32'h0;
    end else if (ce) begin
      rd_data <= rd_en ? next_rd : 32'h0;
    end
  end

  // ==========================================================
  // interrupt status, set wins over clear
  assign status_set[ctbt_pkg::ST_REQ_BIT] = next_state == ctbt_pkg::ST_REQ && state != ctbt_pkg::ST_REQ;
  assign status_set[ctbt_pkg::ST_DONE_BIT] = state == ctbt_pkg::ST_DONE;
  assign status_set[ctbt_pkg::ST_COUNT_BIT] = fifo_wr;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      status <= ctbt_pkg::STATUS_RESET;
      irq <= 1'b0;
    end else if (ce) begin
      status <= (status & ~((wr_en && addr == ctbt_pkg::OFF_STATUS) ? wr_data[2:0] : 3'h0))
                | status_set;
      irq <= |(status & mask);
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_REQ_WAIT: assert property ((ce && state == ctbt_pkg::ST_REQ && !wr_burst && enabled)
    |=> state == ctbt_pkg::ST_REQ && burst_length_request)
    else $error("drive line left request wait without burst lengths");
  AST_REQ_CLEAR: assert property ((ce && wr_burst && last_grp)
    |=> !burst_length_request && state == ctbt_pkg::ST_CXDIS)
    else $error("request not cleared after last burst write");
  AST_GROUP_MAP: assert property ((ce && wr_burst)
    |=> burst[32*$past(grp) +: 32] == $past(wr_data) && grp != $past(grp))
    else $error("burst write not placed in its group of four");
  AST_CLAMP: assert property (($past(state) != ctbt_pkg::ST_CHARGE && $past(ce))
    |-> sense_ground == 8'hFF && clamp_ground == 8'hFF)
    else $error("sense line released outside a burst pulse");
  AST_CAPTURE_END: assert property ((matrix && state == ctbt_pkg::ST_CHARGE &&
    pulse_left == 8'h01) |-> capture[0] == (burst[7:0] != 8'h00))
    else $error("line zero not capturing on the final pulse");
  AST_CX: assert property ((ce && $rose(state == ctbt_pkg::ST_CXDIS))
    |=> cx_discharge && drive_out == 8'h00)
    else $error("cx discharge not shown in its phase");
  AST_FIFO_FULL: assert property (5'(wptr - rptr) <= 5'h10)
    else $error("count written into a full buffer");
  AST_DMA_REQ: assert property ((ce && state == ctbt_pkg::ST_REQ) |-> burst_length_request)
    else $error("burst request handshake low while waiting");
  AST_IRQ: assert property ($past(ce) |-> irq == $past(|(status & mask)))
    else $error("interrupt does not follow masked status");

  COV_MATRIX_TWO_GROUPS: cover property (wr_burst && !grp ##[1:50] wr_burst && grp && last_grp);
  COV_SELF_DONE: cover property (!matrix && state == ctbt_pkg::ST_DONE);
  COV_MATRIX_NEXT_LINE: cover property (state == ctbt_pkg::ST_STORE && next_state == ctbt_pkg::ST_REQ);
  COV_FIFO_FULL: cover property (fifo_full);
endmodule
`default_nettype wire

// *** rtl/ctbt_count_mem.sv ***
/*
  ctbt_count_mem: small store for acquired counts, registered read.
  assumes: read address presented one cycle before the data are used.
*/
`timescale 1ns/100ps
`default_nettype none
module ctbt_count_mem (
  input wire logic core_clk,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [3:0] rd_addr,
  output logic [15:0] rd_data
);
  // ==========================================================
  // storage
  logic [15:0] mem [ctbt_pkg::MEM_DEPTH];

  always_ff @(posedge core_clk) begin
    if (ce) begin
      if (wr_en) mem[wr_addr] <= wr_data;
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// *** rtl/ctbt_pkg.sv ***
/*
  ctbt_pkg: register map, field positions, reset values, sizes and the
  sequencer states of the touch burst timing block.
  assumes: one clock domain, 32-bit register port with byte addresses.
*/
package ctbt_pkg;
  // ==========================================================
  // sizes
  localparam int unsigned NLINES = 8;
  localparam int unsigned NTYPES = 4;
  localparam int unsigned MEM_DEPTH = 16;
  localparam int unsigned PTR_W = 5;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CFG_BASE = 8'h04;
  localparam logic [7:0] OFF_CFG_STEP = 8'h08;
  localparam logic [7:0] OFF_CFG_ONE = 8'h04;
  localparam logic [7:0] OFF_MG_CFG2 = 8'h24;
  localparam logic [7:0] OFF_BURST = 8'h28;
  localparam logic [7:0] OFF_COUNT = 8'h2C;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam logic [7:0] OFF_MASK = 8'h34;
  localparam logic [7:0] OFF_STATE = 8'h38;
  // ==========================================================
  // acquisition types
  localparam logic [1:0] TYPE_AUTO = 2'h0;
  localparam logic [1:0] TYPE_GRPA = 2'h1;
  localparam logic [1:0] TYPE_GRPB = 2'h2;
  localparam logic [1:0] TYPE_MATRIX = 2'h3;
  // ==========================================================
  // field positions
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_START_BIT = 1;
  localparam int unsigned CTRL_TYPE_LSB = 2;
  localparam int unsigned CTRL_NSENSE_LSB = 4;
  localparam int unsigned CTRL_NDRIVE_LSB = 7;
  localparam int unsigned CTRL_W = 10;
  localparam int unsigned DIV_LSB = 0;
  localparam int unsigned CHARGE_LSB = 8;
  localparam int unsigned SETTLE_LSB = 16;
  localparam int unsigned ST_REQ_BIT = 0;
  localparam int unsigned ST_DONE_BIT = 1;
  localparam int unsigned ST_COUNT_BIT = 2;
  // ==========================================================
  // reset values
  localparam logic [9:0] CTRL_RESET = 10'h000;
  localparam logic [23:0] CFG0_RESET = 24'h000000;
  localparam logic [7:0] LEN_RESET = 8'h00;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  // ==========================================================
  // sequencer states
  typedef enum logic [7:0] {
    ST_IDLE   = 8'b0000_0001,
    ST_REQ    = 8'b0000_0010,
    ST_CXDIS  = 8'b0000_0100,
    ST_CHARGE = 8'b0000_1000,
    ST_SETTLE = 8'b0001_0000,
    ST_DISCH  = 8'b0010_0000,
    ST_STORE  = 8'b0100_0000,
    ST_DONE   = 8'b1000_0000
  } ctbt_state_e;
endpackage

// *** rtl/ctbt_prescaler.sv ***
/*
  ctbt_prescaler: divides the module clock to one sampling tick.
  assumes: div stable while used; ce freezes the divider.
*/
`timescale 1ns/100ps
`default_nettype none
module ctbt_prescaler (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] div,
  output logic tick
);
  // ==========================================================
  // divider
  logic [8:0] cnt;
  logic [8:0] full;
  assign full = {div, 1'b1};

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt <= 9'h000;
      tick <= 1'b0;
    end else if (ce) begin
      // period is 2(div+1) clocks
      if (cnt >= full) begin
        cnt <= 9'h000;
        tick <= 1'b1;
      end else begin
        cnt <= cnt + 9'h001;
        tick <= 1'b0;
      end
    end
  end

  // ==========================================================
  // checks
  logic [9:0] gap;
  logic armed;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gap <= 10'h000;
      armed <= 1'b0;
    end else if (ce) begin
      gap <= tick ? 10'h001 : gap + 10'h001;
      if (tick) armed <= 1'b1;
      if ($past(div) != div) armed <= 1'b0;
    end
  end

  AST_PRESC_PERIOD: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ce && tick && armed && $stable(div)) |-> (gap == {1'b0, full} + 10'h001))
    else $error("prescaler period is not 2(div+1)");
endmodule
`default_nettype wire

// *** testbench/capacitive_touch_burst_timing_bench.sv ***
/*
  capacitive_touch_burst_timing_bench: self-checking bench for ctbt_core.
  assumes: ctbt_pkg and ctbt_sensor_model compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
module capacitive_touch_burst_timing_bench;
  // ==========================================================
  // signals
  typedef struct {logic [31:0] exp; logic [31:0] mask;} ctbt_note_s;
  logic core_clk = 1'b0, sys_rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic arm = 1'b0, rd_seen = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0, rd_data;
  logic [7:0] sense_cmp, drive_out, sense_ground, clamp_ground, bl[5];
  logic self_charge, cx_discharge, burst_length_request, dma_count_req, irq;
  localparam int SENSE_THR = 6;
  logic [7:0] mx = 8'h00;
  logic drv_q = 1'b0;
  int err_count = 0, compares = 0, cycles = 0, drv_pulses = 0, cx_cycles = 0;
  ctbt_note_s notes[$];
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  ctbt_core uut (.core_clk(core_clk), .sys_rst(sys_rst), .ce(1'b1), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .sense_cmp(sense_cmp), .drive_out(drive_out), .sense_ground(sense_ground),
    .clamp_ground(clamp_ground), .self_charge(self_charge), .cx_discharge(cx_discharge),
    .burst_length_request(burst_length_request), .dma_count_req(dma_count_req), .irq(irq));
  ctbt_sensor_model #(.THR(SENSE_THR)) sensor (.core_clk(core_clk), .arm(arm),
    .self_charge(self_charge), .sense_ground(sense_ground), .sense_cmp(sense_cmp));
  // ==========================================================
  // checking and bus tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wr_en <= w;
    rd_en <= r;
    addr <= a;
    wr_data <= d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{e & m, m});
    bus(1'b0, 1'b1, a, 32'h0);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 32'h0);
  endtask
  task automatic wait_irq();
    // let a stale irq from a status clear drain first
    idle(2);
    for (int i = 0; i < 5000 && irq !== 1'b1; i++) begin
      idle(1);
    end
    check("irq", {31'h0, irq}, 32'h1);
  endtask
  // ==========================================================
  // read data watcher and timeout
  always @(posedge core_clk) begin
    if (rd_seen) begin
      check("rd_data", rd_data & notes[0].mask, notes[0].exp);
      void'(notes.pop_front());
    end
    rd_seen <= rd_en;
    drv_q <= drive_out[0];
    if (drive_out[0] && !drv_q) drv_pulses++;
    if (cx_discharge) cx_cycles++;
    cycles = cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      give_verdict();
    end
  end
  // ==========================================================
  // tests
  initial begin
    void'($urandom(68));
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    idle(1);
    check("sense_ground", {24'h0, sense_ground}, 32'hFF);
    check("clamp_ground", {24'h0, clamp_ground}, 32'hFF);
    check("request", {31'h0, burst_length_request}, 32'h0);
    rd(ctbt_pkg::OFF_STATUS, 32'h0, 32'hFFFFFFFF);
    rd(8'h3C, 32'h0, 32'hFFFFFFFF);
    $display("test reset done");
    for (int i = 0; i < 5; i++) bl[i] = 8'($urandom_range(40, 1));
    for (int i = 0; i < 5; i++) if (bl[i] > mx) mx = bl[i];
    wr(8'h1C, 32'h0001_0100);
    wr(8'h20, 32'h1);
    wr(ctbt_pkg::OFF_MG_CFG2, 32'h2);
    wr(ctbt_pkg::OFF_MASK, 32'h1);
    // start is decoded against the previous control value
    wr(ctbt_pkg::OFF_CTRL, 32'h4D);
    arm <= 1'b1;
    wr(ctbt_pkg::OFF_CTRL, 32'h4F);
    arm <= 1'b0;
    wait_irq();
    check("request", {31'h0, burst_length_request}, 32'h1);
    rd(ctbt_pkg::OFF_STATUS, 32'h1, 32'h1);
    wr(ctbt_pkg::OFF_BURST, {bl[3], bl[2], bl[1], bl[0]});
    idle(4);
    check("request", {31'h0, burst_length_request}, 32'h1);
    wr(ctbt_pkg::OFF_BURST, {24'h0, bl[4]});
    idle(4);
    check("request", {31'h0, burst_length_request}, 32'h0);
    wr(ctbt_pkg::OFF_STATUS, 32'h7);
    wr(ctbt_pkg::OFF_MASK, 32'h2);
    wait_irq();
    check("drive_pulses", 32'(drv_pulses), {24'h0, mx});
    check("cx_seen", {31'h0, cx_cycles != 0}, 32'h1);
    check("dma_count_req", {31'h0, dma_count_req}, 32'h1);
    for (int i = 0; i < 5; i++) rd(ctbt_pkg::OFF_COUNT, {21'h0, 3'(i), bl[i]}, '1);
    rd(ctbt_pkg::OFF_COUNT, 32'h0, '1);
    idle(3);
    check("dma_count_req", {31'h0, dma_count_req}, 32'h0);
    $display("test matrix done");
    for (int t = 0; t < 3; t++) begin
      wr(8'(8'h04 + 8 * t), 32'h0001_0101);
      wr(8'(8'h08 + 8 * t), 32'h1);
      wr(ctbt_pkg::OFF_STATUS, 32'h7);
      wr(ctbt_pkg::OFF_CTRL, 32'(1 + 4 * t));
      arm <= 1'b1;
      wr(ctbt_pkg::OFF_CTRL, 32'(3 + 4 * t));
      arm <= 1'b0;
      wait_irq();
      check("request", {31'h0, burst_length_request}, 32'h0);
      idle(3);
      rd(ctbt_pkg::OFF_COUNT, 32'(SENSE_THR), '1);
      rd(ctbt_pkg::OFF_COUNT, 32'h0, '1);
      idle(3);
      $display("test self type %0d done", t);
    end
    give_verdict();
  end
endmodule
`default_nettype wire

// *** testbench/ctbt_sensor_model.sv ***
/*
  ctbt_sensor_model: electrode and sampling capacitor stand-in.
  assumes: bench raises arm for a cycle before each acquisition.
*/
`timescale 1ns/100ps
`default_nettype none
module ctbt_sensor_model #(
  parameter int THR = 6
) (
  input wire logic core_clk,
  input wire logic arm,
  input wire logic self_charge,
  input wire logic [7:0] sense_ground,
  output logic [7:0] sense_cmp
);
  // ==========================================================
  // charge collected on line zero
  logic [7:0] pulses = 8'h00;
  logic chg_q = 1'b0;
  always_ff @(posedge core_clk) begin
    chg_q <= self_charge;
    if (arm) begin
      pulses <= 8'h00;
    end else if (self_charge && !chg_q && !sense_ground[0]) begin
      pulses <= pulses + 8'h01;
    end
  end
  assign sense_cmp = {7'h00, pulses >= 8'(THR)};
endmodule
`default_nettype wire
